// ==== logic/fst_cfg.svh ====
// fragmented sample transfer: offsets, sizes and reset values
`ifndef FST_CFG_SVH
`define FST_CFG_SVH

// fragment size, fixed for the writer, between 1 KiB and 64 KiB
`define FST_FRAG_SIZE 32'h0000_0800
`define FST_FRAG_SHIFT 5'h0b
// bytes of submessage overhead ahead of the payload bytes
`define FST_SUBMSG_HDR 16'h0024
// request window length in sequence numbers
`define FST_WIN 32
// packed message word: kind, seq, aux, frag_start, frag_count, qos
`define FST_MSG_W 115
`define FST_SEQ_RST 32'h0000_0000
`define FST_FRAG_FIRST 32'h0000_0001

`endif

// ==== logic/fst_pkg.sv ====
// fragmented sample transfer: types
package fst_pkg;

    typedef enum logic [1:0] {
        FST_IDLE = 2'h0,
        FST_SEND = 2'h1,
        FST_HBEAT = 2'h3,
        FST_HBFRAG = 2'h2
    } fst_state_t;

    typedef enum logic [1:0] {
        FST_KIND_DATA = 2'h0,
        FST_KIND_DATAFRAG = 2'h1,
        FST_KIND_HEARTBEAT = 2'h2,
        FST_KIND_HBFRAG = 2'h3
    } fst_kind_t;

endpackage

// ==== logic/fst_buf.sv ====
// two-entry buffer with registered head, valid/ready on both sides
`timescale 1ns/1ps

module fst_buf #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] tail;
    logic [1:0] count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 2'h0;
            out_valid <= 1'b0;
            in_ready <= 1'b1;
        end else if (ce) begin
            case ({push, pop})
                2'b10: begin
                    count <= count + 2'h1;
                    out_valid <= 1'b1;
                    in_ready <= (count == 2'h0);
                end
                2'b01: begin
                    count <= count - 2'h1;
                    out_valid <= (count == 2'h2);
                    in_ready <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_data <= '0;
            tail <= '0;
        end else if (ce) begin
            if (push && pop) begin
                if (count == 2'h2) begin
                    out_data <= tail;
                    tail <= in_data;
                end else begin
                    out_data <= in_data;
                end
            end else if (pop) begin
                out_data <= tail;
            end else if (push) begin
                if (count == 2'h0) begin
                    out_data <= in_data;
                end else begin
                    tail <= in_data;
                end
            end
        end
    end

endmodule // fst_buf

// ==== logic/fst_writer.sv ====
// fragmented sample transfer: writer-side framer and reader proxy state
// Contract
// - one fixed fragment size for all readers
// - fragment size between 1 KiB and 64 KiB
// - smallest transport must carry one fragment
// - fragments sent in increasing index order
// - fragment only when transport requires it
// - decide fragmenting per sequence number
// - inline qos rides fragment one
// - pack as many fragments per submessage
// - heartbeat advertises only complete samples
// - fragment heartbeat announces partial availability
// - proxy keeps highest sent sequence number
// - next unsent is smallest above highest sent
// - requests kept as base plus bitmap
// - one submessage carries the whole set
`timescale 1ns/1ps
`include "fst_cfg.svh"

module fst_writer
    import fst_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [15:0] link_max_size,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [31:0] sample_seq,
    input wire logic [31:0] sample_len,
    input wire logic sample_qos,
    input wire logic avail_valid,
    input wire logic [31:0] avail_seq,
    input wire logic hb_req,
    input wire logic [31:0] hb_first,
    input wire logic hbfrag_en,
    input wire logic part_valid,
    input wire logic [31:0] part_seq,
    input wire logic [31:0] part_frags,
    input wire logic nack_valid,
    input wire logic [31:0] nack_base,
    input wire logic [31:0] nack_set,
    input wire logic req_take,
    output logic req_valid,
    output logic [31:0] req_seq,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic [1:0] msg_kind,
    output logic [31:0] msg_seq,
    output logic [31:0] msg_aux,
    output logic [31:0] msg_frag_start,
    output logic [15:0] msg_frag_count,
    output logic msg_qos,
    output logic [31:0] top_sent_sequence,
    output logic unsent_pending,
    output logic [31:0] next_unsent_seq,
    output logic cfg_err
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    fst_state_t state;
    fst_state_t next_state;
    logic [31:0] cur_seq, cur_frag, frags_left, hb_first_q, hb_part_seq, hb_part_frags;
    logic [31:0] avail_top, total_frags, win_base, eff_base, next_base;
    logic cur_whole, cur_qos, hb_pending, hb_part, take, whole_fits, last_chunk, push;
    logic buf_in_ready, sample_done;
    logic [15:0] per_msg, chunk;
    logic [32:0] len_round;
    logic [`FST_MSG_W-1:0] push_data, head;
    logic [`FST_WIN-1:0] bitmap, hit, next_bitmap;

    ////////////////////////////////////////////////////////////////////////////
    // fragment geometry

    // fixed size for every reader, so an index always names the same bytes
    always_comb begin
        if (link_max_size < `FST_SUBMSG_HDR) begin
            per_msg = 16'h0000;
        end else begin
            per_msg = (link_max_size - `FST_SUBMSG_HDR) >> `FST_FRAG_SHIFT;
        end
    end

    assign whole_fits = ({1'b0, sample_len} + {17'h0_0000, `FST_SUBMSG_HDR})
        <= {17'h0_0000, link_max_size};
    assign len_round = {1'b0, sample_len} + {1'b0, `FST_FRAG_SIZE} - 33'h0_0000_0001;
    assign total_frags = 32'(len_round >> `FST_FRAG_SHIFT);
    assign chunk = (frags_left < {16'h0000, per_msg}) ? frags_left[15:0] : per_msg;
    assign last_chunk = (frags_left <= {16'h0000, per_msg});
    assign take = sample_valid && sample_ready;

    // smallest transport too small for one fragment: refuse all samples
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_err <= 1'b0;
        end else if (ce) begin
            cfg_err <= (per_msg == 16'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        next_state = state;
        push = 1'b0;
        push_data = '0;
        sample_done = 1'b0;
        case (state)
            FST_IDLE: begin
                if (hb_pending) begin
                    next_state = FST_HBEAT;
                end else if (take) begin
                    next_state = FST_SEND;
                end
            end
            FST_SEND: begin
                if (buf_in_ready) begin
                    push = 1'b1;
                    if (cur_whole) begin
                        push_data = {FST_KIND_DATA, cur_seq, 32'h0000_0000,
                            32'h0000_0000, 16'h0000, cur_qos};
                        sample_done = 1'b1;
                        next_state = FST_IDLE;
                    end else begin
                        push_data = {FST_KIND_DATAFRAG, cur_seq, 32'h0000_0000,
                            cur_frag, chunk,
                            cur_qos && (cur_frag == `FST_FRAG_FIRST)};
                        if (last_chunk) begin
                            sample_done = 1'b1;
                            next_state = FST_IDLE;
                        end
                    end
                end
            end
            FST_HBEAT: begin
                if (buf_in_ready) begin
                    push = 1'b1;
                    // whole advertised range in one submessage
                    push_data = {FST_KIND_HEARTBEAT, hb_first_q, avail_top,
                        32'h0000_0000, 16'h0000, 1'b0};
                    next_state = hb_part ? FST_HBFRAG : FST_IDLE;
                end
            end
            FST_HBFRAG: begin
                if (buf_in_ready) begin
                    push = 1'b1;
                    push_data = {FST_KIND_HBFRAG, hb_part_seq, hb_part_frags,
                        32'h0000_0000, 16'h0000, 1'b0};
                    next_state = FST_IDLE;
                end
            end
            default: begin
                next_state = FST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= FST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ready only when the next cycle is idle and no heartbeat waits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_ready <= 1'b0;
        end else if (ce) begin
            sample_ready <= (next_state == FST_IDLE) && !hb_pending && !hb_req
                && !(per_msg == 16'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // current sample

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_seq <= `FST_SEQ_RST;
            cur_frag <= `FST_FRAG_FIRST;
            frags_left <= 32'h0000_0000;
            cur_whole <= 1'b0;
            cur_qos <= 1'b0;
        end else if (ce) begin
            if (take && state == FST_IDLE && !hb_pending) begin
                cur_seq <= sample_seq;
                cur_frag <= `FST_FRAG_FIRST;
                frags_left <= total_frags;
                cur_whole <= whole_fits;
                cur_qos <= sample_qos;
            end else if (push && state == FST_SEND && !cur_whole) begin
                cur_frag <= cur_frag + {16'h0000, chunk};
                frags_left <= frags_left - {16'h0000, chunk};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // heartbeat requests and availability

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hb_pending <= 1'b0;
            hb_first_q <= `FST_SEQ_RST;
            hb_part <= 1'b0;
            hb_part_seq <= `FST_SEQ_RST;
            hb_part_frags <= 32'h0000_0000;
        end else if (ce) begin
            if (hb_req) begin
                hb_pending <= 1'b1;
                hb_first_q <= hb_first;
                hb_part <= hbfrag_en && part_valid;
                hb_part_seq <= part_seq;
                hb_part_frags <= part_frags;
            end else if (state == FST_HBEAT && push) begin
                hb_pending <= 1'b0;
            end
        end
    end

    // only samples with every fragment present move the advertised top
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avail_top <= `FST_SEQ_RST;
        end else if (ce) begin
            if (avail_valid && avail_seq > avail_top) begin
                avail_top <= avail_seq;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reader proxy: highest sent and next unsent

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            top_sent_sequence <= `FST_SEQ_RST;
        end else if (ce) begin
            if (sample_done && cur_seq > top_sent_sequence) begin
                top_sent_sequence <= cur_seq;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unsent_pending <= 1'b0;
            next_unsent_seq <= `FST_FRAG_FIRST;
        end else if (ce) begin
            unsent_pending <= (avail_top > top_sent_sequence);
            next_unsent_seq <= top_sent_sequence + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request window: base plus bitmap

    assign eff_base = (bitmap == '0) ? nack_base : win_base;

    // beyond the window the request is dropped; the reader will ask again
    genvar gi;
    generate
        for (gi = 0; gi < `FST_WIN; gi++) begin : g_hit
            logic [31:0] rel;
            assign rel = eff_base + 32'(gi) - nack_base;
            assign hit[gi] = nack_valid && (rel < 32'(`FST_WIN))
                && nack_set[rel[4:0]];
        end
    endgenerate

    // a new request in the cycle of a take wins over the clear
    always_comb begin
        next_bitmap = bitmap;
        next_base = eff_base;
        if (req_take && bitmap[0]) begin
            next_bitmap[0] = 1'b0;
        end
        next_bitmap = next_bitmap | hit;
        if (next_bitmap != '0 && !next_bitmap[0]) begin
            next_bitmap = next_bitmap >> 1;
            next_base = eff_base + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitmap <= '0;
            win_base <= `FST_SEQ_RST;
            req_valid <= 1'b0;
            req_seq <= `FST_SEQ_RST;
        end else if (ce) begin
            bitmap <= next_bitmap;
            win_base <= next_base;
            req_valid <= next_bitmap[0];
            req_seq <= next_base;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outgoing submessage buffer

    fst_buf #(
        .WIDTH(`FST_MSG_W)
    ) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data(push_data),
        .out_valid(msg_valid),
        .out_ready(msg_ready),
        .out_data(head)
    );

    assign msg_kind = head[114:113];
    assign msg_seq = head[112:81];
    assign msg_aux = head[80:49];
    assign msg_frag_start = head[48:17];
    assign msg_frag_count = head[16:1];
    assign msg_qos = head[0];

endmodule // fst_writer

// ==== verification/fst_writer_checker.sv ====
// port checker for the fragmented sample writer
`timescale 1ns/1ps
module fst_writer_checker
    import fst_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] link_max_size,
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire logic avail_valid,
    input wire logic [31:0] avail_seq,
    input wire logic nack_valid,
    input wire logic [31:0] nack_base,
    input wire logic [31:0] nack_set,
    input wire logic req_valid,
    input wire logic [31:0] req_seq,
    input wire logic msg_valid,
    input wire logic msg_ready,
    input wire logic [1:0] msg_kind,
    input wire logic [31:0] msg_seq,
    input wire logic [31:0] msg_aux,
    input wire logic [31:0] msg_frag_start,
    input wire logic [15:0] msg_frag_count,
    input wire logic msg_qos,
    input wire logic cfg_err
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic [31:0] avail_top, prev_seq, prev_end, base_q;
    logic have_prev;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            avail_top <= '0;
            base_q <= '0;
        end else begin
            if (avail_valid) begin
                avail_top <= avail_seq;
            end
            if (nack_valid) begin
                base_q <= nack_base;
            end
        end
    end
    // end index of the last fragment message taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            have_prev <= 1'b0;
            prev_seq <= '0;
            prev_end <= '0;
        end else if (msg_valid && msg_ready && msg_kind == FST_KIND_DATAFRAG) begin
            have_prev <= 1'b1;
            prev_seq <= msg_seq;
            prev_end <= msg_frag_start + 32'(msg_frag_count);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_stall;
        msg_valid && !msg_ready;
    endsequence
    sequence s_frag;
        msg_valid && msg_kind == FST_KIND_DATAFRAG;
    endsequence
    sequence s_take;
        sample_valid && sample_ready;
    endsequence
    AST_MSG_HOLD: assert property (s_stall |=> msg_valid && $stable(msg_seq)
        && $stable(msg_kind) && $stable(msg_frag_start) && $stable(msg_aux))
        else $error("message changed while stalled");
    AST_DATA_WHOLE: assert property (msg_valid && msg_kind == FST_KIND_DATA
        |-> msg_frag_count == 16'h0) else $error("whole data with fragment count");
    AST_FRAG_FIT: assert property (s_frag |-> msg_frag_count != 16'h0
        && (32'(msg_frag_count) << 11) + 32'h24 <= 32'(link_max_size))
        else $error("fragment message exceeds link");
    AST_QOS_FIRST: assert property (s_frag ##0 msg_frag_start != 32'h1 |-> !msg_qos)
        else $error("qos on later fragment");
    AST_FRAG_ORDER: assert property (s_frag ##0 msg_ready && have_prev
        && msg_seq == prev_seq |-> msg_frag_start == prev_end)
        else $error("fragment index out of order");
    AST_HB_RANGE: assert property (msg_valid && msg_kind == FST_KIND_HEARTBEAT
        |-> msg_aux == avail_top) else $error("heartbeat range not complete");
    AST_CFG_REFUSE: assert property (cfg_err |=> !sample_ready)
        else $error("sample offered with undersized link");
    AST_TAKE_BUSY: assert property (s_take |=> !sample_ready)
        else $error("sample ready during transfer");
    AST_REQ_LOAD: assert property (!req_valid && nack_valid && nack_set[0]
        |-> ##[1:3] req_valid && req_seq == base_q) else $error("request base not loaded");
endmodule // fst_writer_checker

bind fst_writer fst_writer_checker u_chk (.clk(clk), .reset_n(reset_n),
    .link_max_size(link_max_size), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .avail_valid(avail_valid), .avail_seq(avail_seq), .nack_valid(nack_valid),
    .nack_base(nack_base), .nack_set(nack_set), .req_valid(req_valid), .req_seq(req_seq),
    .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_kind(msg_kind), .msg_seq(msg_seq),
    .msg_aux(msg_aux), .msg_frag_start(msg_frag_start), .msg_frag_count(msg_frag_count),
    .msg_qos(msg_qos), .cfg_err(cfg_err));

// ==== verification/fst_reader_model.sv ====
// far-side message consumer: stalls on command, logs what it takes
`timescale 1ns/1ps
module fst_reader_model
    import fst_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic stall,
    input wire logic msg_valid,
    output logic msg_ready,
    input wire logic [1:0] msg_kind,
    input wire logic [31:0] msg_seq,
    input wire logic [31:0] msg_aux,
    input wire logic [31:0] msg_frag_start,
    input wire logic [15:0] msg_frag_count,
    input wire logic msg_qos
);
    typedef struct packed {
        logic [1:0] kind;
        logic [31:0] seq;
        logic [31:0] aux;
        logic [31:0] start;
        logic [15:0] cnt;
        logic qos;
    } fst_rec_t;
    fst_rec_t log_q[$];
    logic [31:0] frag_seen, last_seq;
    // fragment nack for a heartbeat reply: a bit for each of the first n fragments not yet seen
    function automatic logic [31:0] frag_nack(input int n);
        return ~frag_seen & ((32'h1 << n) - 32'h1);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            msg_ready <= 1'b0;
            frag_seen <= '0;
            last_seq <= '0;
            log_q.delete();
        end else begin
            msg_ready <= #1 !stall;
            if (msg_valid && msg_ready) begin
                log_q.push_back('{msg_kind, msg_seq, msg_aux, msg_frag_start,
                    msg_frag_count, msg_qos});
                // arrival map per sample, any order, duplicates harmless
                if (msg_kind == FST_KIND_DATAFRAG) begin
                    frag_seen <= ((msg_seq == last_seq) ? frag_seen : 32'h0)
                        | (((32'h1 << msg_frag_count) - 32'h1) << (msg_frag_start - 32'h1));
                    last_seq <= msg_seq;
                end
            end
        end
    end
endmodule // fst_reader_model

// ==== verification/fragmented_sample_transfer_bench.sv ====
// self-checking bench for the fragmented sample writer
`timescale 1ns/1ps
module fragmented_sample_transfer_bench import fst_pkg::*; ;
    logic clk, reset_n, ce, sample_valid, sample_qos, avail_valid, hb_req, hbfrag_en;
    logic part_valid, nack_valid, req_take, stall, sample_ready, req_valid, msg_valid;
    logic msg_ready, msg_qos, unsent_pending, cfg_err;
    logic [1:0] msg_kind;
    logic [15:0] link_max_size, msg_frag_count;
    logic [31:0] sample_seq, sample_len, avail_seq, hb_first, part_seq, part_frags;
    logic [31:0] nack_base, nack_set, req_seq, msg_seq, msg_aux, msg_frag_start;
    logic [31:0] top_sent_sequence, next_unsent_seq;
    int fail_count, check_count;
    ////////////////////////////////////////////////////////////////////////////////
    fst_writer u_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .link_max_size(link_max_size),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_seq(sample_seq),
        .sample_len(sample_len), .sample_qos(sample_qos), .avail_valid(avail_valid),
        .avail_seq(avail_seq), .hb_req(hb_req), .hb_first(hb_first), .hbfrag_en(hbfrag_en),
        .part_valid(part_valid), .part_seq(part_seq), .part_frags(part_frags),
        .nack_valid(nack_valid), .nack_base(nack_base), .nack_set(nack_set),
        .req_take(req_take), .req_valid(req_valid), .req_seq(req_seq),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_kind(msg_kind), .msg_seq(msg_seq),
        .msg_aux(msg_aux), .msg_frag_start(msg_frag_start), .msg_frag_count(msg_frag_count),
        .msg_qos(msg_qos), .top_sent_sequence(top_sent_sequence),
        .unsent_pending(unsent_pending), .next_unsent_seq(next_unsent_seq), .cfg_err(cfg_err));
    fst_reader_model u_reader (.clk(clk), .reset_n(reset_n), .stall(stall),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_kind(msg_kind), .msg_seq(msg_seq),
        .msg_aux(msg_aux), .msg_frag_start(msg_frag_start), .msg_frag_count(msg_frag_count),
        .msg_qos(msg_qos));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one sample offer, held until taken
    task automatic send(input logic [31:0] s, input logic [31:0] l, input logic q);
        int n;
        n = 0;
        sample_seq = s;
        sample_len = l;
        sample_qos = q;
        sample_valid = 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (sample_ready !== 1'b1 && n < 200);
        #1;
        sample_valid = 1'b0;
        check(32'(n < 200), 32'h1);
    endtask
    // next message taken by the far side
    task automatic expect_msg(input logic [1:0] k, input logic [31:0] s, input logic [31:0] a,
            input logic [31:0] st, input logic [15:0] c, input logic q);
        int n;
        n = 0;
        while (u_reader.log_q.size() == 0 && n < 100) begin
            tick(1);
            n++;
        end
        check(32'(u_reader.log_q.size() != 0), 32'h1);
        if (u_reader.log_q.size() == 0) begin
            return;
        end
        check(u_reader.log_q[0].kind, k);
        check(u_reader.log_q[0].seq, s);
        if (k[1]) begin
            check(u_reader.log_q[0].aux, a);
        end else begin
            check(u_reader.log_q[0].cnt, c);
        end
        if (k == FST_KIND_DATAFRAG) begin
            check(u_reader.log_q[0].start, st);
            check(u_reader.log_q[0].qos, q);
        end
        void'(u_reader.log_q.pop_front());
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        reset_n = 1'b0;
        tick(8);
        check(next_unsent_seq, 32'h1);
        check(top_sent_sequence, 32'h0);
        check({msg_valid, req_valid, sample_ready, cfg_err, unsent_pending}, 32'h0);
        reset_n = 1'b1;
        tick(2);
        check(sample_ready, 32'h1);
    endtask
    task automatic t_whole();
        send(32'h1, 32'h1000, 1'b0);
        expect_msg(FST_KIND_DATA, 32'h1, 32'h0, 32'h0, 16'h0, 1'b0);
        send(32'h2, 32'h1001, 1'b1);
        expect_msg(FST_KIND_DATAFRAG, 32'h2, 32'h0, 32'h1, 16'h2, 1'b1);
        expect_msg(FST_KIND_DATAFRAG, 32'h2, 32'h0, 32'h3, 16'h1, 1'b0);
        tick(4);
        check(top_sent_sequence, 32'h2);
        check(next_unsent_seq, 32'h3);
    endtask
    task automatic t_stall();
        stall = 1'b1;
        link_max_size = 16'h0824;
        send(32'h3, 32'h2800, 1'b0);
        tick(30);
        check(u_reader.log_q.size(), 32'h0);
        check(sample_ready, 32'h0);
        stall = 1'b0;
        for (int i = 1; i <= 5; i++) begin
            expect_msg(FST_KIND_DATAFRAG, 32'h3, 32'h0, 32'(i), 16'h1, 1'b0);
        end
        check(u_reader.frag_seen, 32'h1f);
        check(u_reader.frag_nack(5), 32'h0);
        check(u_reader.frag_nack(6), 32'h20);
        check(top_sent_sequence, 32'h3);
    endtask
    task automatic t_hbeat();
        link_max_size = 16'h1024;
        avail_seq = 32'h5;
        avail_valid = 1'b1;
        tick(1);
        avail_valid = 1'b0;
        tick(2);
        check(unsent_pending, 32'h1);
        hbfrag_en = 1'b1;
        for (int i = 0; i < 2; i++) begin
            hb_req = 1'b1;
            tick(1);
            hb_req = 1'b0;
            expect_msg(FST_KIND_HEARTBEAT, 32'h1, 32'h5, 32'h0, 16'h0, 1'b0);
            if (i == 0) begin
                expect_msg(FST_KIND_HBFRAG, 32'h6, 32'h2, 32'h0, 16'h0, 1'b0);
            end
            hbfrag_en = 1'b0;
        end
        tick(10);
        check(u_reader.log_q.size(), 32'h0);
    endtask
    task automatic t_window();
        // requests for 0xa and 0xc; the later one at 0x64 lies beyond the window and is dropped
        nack_base = 32'ha;
        nack_set = 32'h5;
        nack_valid = 1'b1;
        tick(1);
        nack_base = 32'h64;
        nack_set = 32'h1;
        tick(1);
        nack_valid = 1'b0;
        tick(2);
        check(req_valid, 32'h1);
        check(req_seq, 32'ha);
        for (int i = 0; i < 2; i++) begin
            req_take = 1'b1;
            tick(1);
            req_take = 1'b0;
            tick(6);
            // an empty window follows the offered base
            check(req_seq, i ? 32'h64 : 32'hc);
        end
        check(req_valid, 32'h0);
    endtask
    task automatic t_cfg();
        link_max_size = 16'h0823;
        tick(3);
        check(cfg_err, 32'h1);
        check(sample_ready, 32'h0);
        link_max_size = 16'h1024;
        t_reset();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #50000;
        fail_count++;
        print_verdict();
    end
    initial begin
        {reset_n, sample_valid, sample_qos, avail_valid, hb_req, hbfrag_en} = '0;
        {nack_valid, req_take, stall, sample_seq, sample_len, avail_seq, nack_base} = '0;
        {nack_set} = '0;
        ce = 1'b1;
        link_max_size = 16'h1024;
        hb_first = 32'h1;
        part_valid = 1'b1;
        part_seq = 32'h6;
        part_frags = 32'h2;
        t_reset();
        t_whole();
        t_stall();
        t_hbeat();
        t_window();
        t_cfg();
        print_verdict();
    end
endmodule // fragmented_sample_transfer_bench
